/* File: src/detector_cfg_pkg.sv */
// constants for the baseband detector configuration bank
// assumes an 8-bit register port and a 25 MHz system clock
package detector_cfg_pkg;
	localparam int ADDR_W = 9;
	localparam int DATA_W = 8;
	localparam int PWR_W  = 24;
	// register byte offsets
	localparam logic [8:0] OFS_SLICER     = 9'h031;
	localparam logic [8:0] OFS_RATE       = 9'h03D;
	localparam logic [8:0] OFS_THR_RUN    = 9'h03F;
	localparam logic [8:0] OFS_THR_WAKE   = 9'h040;
	localparam logic [8:0] OFS_THR_LOW    = 9'h041;
	localparam logic [8:0] OFS_RANGE      = 9'h042;
	localparam logic [8:0] OFS_FILTER     = 9'h03C;
	localparam logic [8:0] OFS_NOISE_CFG  = 9'h045;
	localparam logic [8:0] OFS_IRQ_STATUS = 9'h0F0;
	localparam logic [8:0] OFS_IRQ_MASK   = 9'h0F1;
	localparam logic [8:0] OFS_DET_STATE  = 9'h0F2;
	// reset values
	localparam logic [7:0] RST_SLICER   = 8'h02;
	localparam logic [7:0] RST_RATE     = 8'h00;
	localparam logic [7:0] RST_THR      = 8'h00;
	localparam logic [7:0] RST_RANGE    = 8'h7F;
	localparam logic [7:0] RST_FILTER   = 8'h07;
	localparam logic [7:0] RST_NOISE_CFG = 8'h07;
	// writable bit masks
	localparam logic [7:0] MSK_SLICER   = 8'h1F;
	localparam logic [7:0] MSK_RANGE    = 8'h3F;
	localparam logic [7:0] MSK_FILTER   = 8'h0F;
	localparam logic [7:0] MSK_IRQ      = 8'h07;
	// field positions
	localparam int BW_SEL_LSB  = 0;
	localparam int BW_SCA_LSB  = 3;
	localparam int RNG_LOW_LSB = 0;
	localparam int RNG_FSK_LSB = 2;
	localparam int RNG_ASK_LSB = 4;
	localparam int DET_SEL_LSB = 4;
	localparam logic [1:0] DET_SEL_SIG_LOW = 2'h3;
	// irq status bit positions
	localparam int IRQ_DET_RISE = 0;
	localparam int IRQ_DET_FALL = 1;
	localparam int IRQ_LOW_RISE = 2;
	// ask code 10 gives factor 7+6
	localparam logic [3:0] ASK_F0 = 4'h6;
	localparam logic [3:0] ASK_F1 = 4'h7;
	localparam logic [3:0] ASK_F2 = 4'hD;
	localparam logic [3:0] ASK_F3 = 4'h8;
endpackage

/* File: src/threshold_scaler.sv */
// scales one 8-bit detect threshold by two to a range factor, registered
// assumes factor codes already decoded to a 4-bit shift amount
`timescale 1ns/100ps
`default_nettype none
module threshold_scaler
(
	input  wire logic                         clk,
	input  wire logic                         rst_b,
	input  wire logic [7:0]                   threshold,
	input  wire logic [3:0]                   shiftAmount,
	output logic      [detector_cfg_pkg::PWR_W-1:0] scaled
);
	import detector_cfg_pkg::*;

	logic [PWR_W-1:0] scaledReg;
	logic [PWR_W-1:0] scaledNext;

	always_comb begin
		scaledNext = PWR_W'({16'h0000, threshold}) << shiftAmount;
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			scaledReg <= '0;
		end else begin
			scaledReg <= scaledNext;
		end
	end

	assign scaled = scaledReg;
endmodule
`default_nettype wire

/* File: src/baseband_detector_config_bank.sv */
// configuration bank for the baseband detector, slicer and rate converter
// assumes a single-cycle register port and measured power from the datapath
// What this block does
// - 8-bit rate tune word sets converter output rate, 00h equal, FFh half
// - slicer scaling codes 00..11 select 1/2, 1/4, 1/8, 1/16
// - manual slicer bandwidth codes 000..101 select 1/8 to 1/48; 110, 111 unused
// - run mode uses its own 8-bit threshold, reset zero
// - wakeup uses a separate 8-bit threshold, reset zero
// - low-level threshold applies only when detector select equals 11
// - chosen threshold is shifted by range factor before power compare
// - amplitude keying range codes give 6, 7, 13, 8; reset code 11
// - frequency keying range codes give 2, 4, 6, 8; reset code 11
// - low-level range codes give 2, 4, 6, 8; reset code 11
// - in mode 11 noise detect is valid only while low threshold exceeded
//
// Chosen here: the plain strobed port.
`timescale 1ns/100ps
`default_nettype none
module baseband_detector_config_bank
(
	input  wire logic                                 clk,
	input  wire logic                                 rst_b,
	input  wire logic [detector_cfg_pkg::ADDR_W-1:0]  regAddr,
	input  wire logic [detector_cfg_pkg::DATA_W-1:0]  regWdata,
	input  wire logic                                 regWrite,
	input  wire logic                                 regRead,
	output logic      [detector_cfg_pkg::DATA_W-1:0]  regRdata,
	input  wire logic                                 wakeupMode,
	input  wire logic                                 fskMode,
	input  wire logic [detector_cfg_pkg::PWR_W-1:0]   signalPower,
	input  wire logic                                 noiseDetectRaw,
	output logic      [4:0]                           filterLength,
	output logic      [7:0]                           rateTuneWord,
	output logic      [1:0]                           slicerBwScaling,
	output logic      [2:0]                           slicerBwSelect,
	output logic      [4:0]                           slicerScaleShift,
	output logic      [5:0]                           slicerBwDivisor,
	output logic      [1:0]                           detectorSelect,
	output logic                                      signalDetect,
	output logic                                      lowLevelExceeded,
	output logic                                      noiseDetectValid,
	output logic                                      irq
);
	import detector_cfg_pkg::*;

	logic [7:0] slicerReg, slicerNext;
	logic [7:0] rateReg, rateNext;
	logic [7:0] thrRunReg, thrRunNext;
	logic [7:0] thrWakeReg, thrWakeNext;
	logic [7:0] thrLowReg, thrLowNext;
	logic [7:0] rangeReg, rangeNext;
	logic [7:0] filterReg, filterNext;
	logic [7:0] ndcfgReg, ndcfgNext;
	logic [7:0] irqStatusReg, irqStatusNext;
	logic [7:0] irqMaskReg, irqMaskNext;
	logic [7:0] rdataReg, rdataNext;
	logic       detReg, detNext;
	logic       lowReg, lowNext;
	logic       nvalidReg, nvalidNext;
	logic [7:0] selThreshold;
	logic [3:0] selShift;
	logic [3:0] lowShift;
	logic [PWR_W-1:0] scaledMain;
	logic [PWR_W-1:0] scaledLow;
	logic [7:0] irqEvents;
	logic       lowActive;

	function automatic logic [3:0] evenFactor(input logic [1:0] code);
		evenFactor = {1'b0, code, 1'b0} + 4'h2;
	endfunction

	function automatic logic [3:0] askFactor(input logic [1:0] code);
		unique case (code)
			2'h0: askFactor = ASK_F0;
			2'h1: askFactor = ASK_F1;
			2'h2: askFactor = ASK_F2;
			2'h3: askFactor = ASK_F3;
		endcase
	endfunction

	// register writes clear unused bits; range bit 6 resets to one
	always_comb begin
		slicerNext  = slicerReg;
		rateNext    = rateReg;
		thrRunNext  = thrRunReg;
		thrWakeNext = thrWakeReg;
		thrLowNext  = thrLowReg;
		rangeNext   = rangeReg;
		filterNext  = filterReg;
		ndcfgNext   = ndcfgReg;
		irqMaskNext = irqMaskReg;
		if (regWrite) begin
			unique case (regAddr)
				OFS_SLICER:    slicerNext  = regWdata & MSK_SLICER;
				OFS_RATE:      rateNext    = regWdata;
				OFS_THR_RUN:   thrRunNext  = regWdata;
				OFS_THR_WAKE:  thrWakeNext = regWdata;
				OFS_THR_LOW:   thrLowNext  = regWdata;
				OFS_RANGE:     rangeNext   = regWdata & MSK_RANGE;
				OFS_FILTER:    filterNext  = regWdata & MSK_FILTER;
				OFS_NOISE_CFG: ndcfgNext   = regWdata;
				OFS_IRQ_MASK:  irqMaskNext = regWdata & MSK_IRQ;
				default: ;
			endcase
		end
	end

	// a write lands on the next edge and leaves its reserved bits reading zero
	a_rate_word: assert property (@(posedge clk) disable iff (!rst_b)
		regWrite && regAddr == OFS_RATE |=> rateTuneWord == $past(regWdata))
		else $error("rate word not stored");
	a_range_write: assert property (@(posedge clk) disable iff (!rst_b)
		regWrite && regAddr == OFS_RANGE |=> rangeReg == ($past(regWdata) & MSK_RANGE))
		else $error("range field not stored");

	// threshold selection by operating mode
	always_comb begin
		selThreshold = wakeupMode ? thrWakeReg : thrRunReg;
		if (fskMode) begin
			selShift = evenFactor(rangeReg[RNG_FSK_LSB +: 2]);
		end else begin
			selShift = askFactor(rangeReg[RNG_ASK_LSB +: 2]);
		end
		lowShift  = evenFactor(rangeReg[RNG_LOW_LSB +: 2]);
		lowActive = (ndcfgReg[DET_SEL_LSB +: 2] == DET_SEL_SIG_LOW);
	end

	// threshold choice by operating mode, factor decode per keying mode
	a_wake_thr: assert property (@(posedge clk) disable iff (!rst_b)
		wakeupMode |-> selThreshold == thrWakeReg)
		else $error("wakeup threshold not used");
	a_run_thr: assert property (@(posedge clk) disable iff (!rst_b)
		!wakeupMode |-> selThreshold == thrRunReg)
		else $error("run threshold not used");
	a_ask_shift: assert property (@(posedge clk) disable iff (!rst_b)
		!fskMode && rangeReg[5:4] == 2'h2 |-> selShift == 4'hD)
		else $error("ask factor wrong");
	a_ask_low: assert property (@(posedge clk) disable iff (!rst_b)
		!fskMode && rangeReg[5:4] == 2'h0 |-> selShift == 4'h6)
		else $error("ask lowest factor wrong");
	a_fsk_shift: assert property (@(posedge clk) disable iff (!rst_b)
		fskMode |-> selShift == {1'b0, rangeReg[3:2], 1'b0} + 4'h2)
		else $error("fsk factor wrong");
	a_fsk_top: assert property (@(posedge clk) disable iff (!rst_b)
		fskMode && rangeReg[3:2] == 2'h3 |-> selShift == 4'h8)
		else $error("fsk top factor wrong");
	a_low_shift: assert property (@(posedge clk) disable iff (!rst_b)
		lowShift == {1'b0, rangeReg[1:0], 1'b0} + 4'h2)
		else $error("low factor wrong");

	threshold_scaler mainScaler (
		.clk         (clk),
		.rst_b       (rst_b),
		.threshold   (selThreshold),
		.shiftAmount (selShift),
		.scaled      (scaledMain)
	);

	threshold_scaler lowScaler (
		.clk         (clk),
		.rst_b       (rst_b),
		.threshold   (thrLowReg),
		.shiftAmount (lowShift),
		.scaled      (scaledLow)
	);

	// scalers answer one edge after their inputs
	a_scaler_out: assert property (@(posedge clk) disable iff (!rst_b)
		1'b1 |=> scaledMain == (PWR_W'($past(selThreshold)) << $past(selShift)))
		else $error("scaling wrong");
	a_low_scaled: assert property (@(posedge clk) disable iff (!rst_b)
		1'b1 |=> scaledLow == (PWR_W'($past(thrLowReg)) << $past(lowShift)))
		else $error("low scaling wrong");

	// detector outputs
	always_comb begin
		detNext    = signalPower > scaledMain;
		lowNext    = lowActive && (signalPower > scaledLow);
		// other selections pass noise detect through unqualified
		nvalidNext = lowActive ? (noiseDetectRaw && lowNext) : noiseDetectRaw;
	end

	// compares are strict: power equal to the threshold does not detect
	a_detect_cmp: assert property (@(posedge clk) disable iff (!rst_b)
		signalPower > scaledMain |=> signalDetect)
		else $error("detect missed");
	a_detect_miss: assert property (@(posedge clk) disable iff (!rst_b)
		!(signalPower > scaledMain) |=> !signalDetect)
		else $error("detect without power");
	a_low_gate: assert property (@(posedge clk) disable iff (!rst_b)
		!lowActive |=> !lowLevelExceeded)
		else $error("low used when off");
	a_low_cmp: assert property (@(posedge clk) disable iff (!rst_b)
		lowActive && signalPower > scaledLow |=> lowLevelExceeded)
		else $error("low level missed");
	a_noise_qual: assert property (@(posedge clk) disable iff (!rst_b)
		noiseDetectValid && $past(lowActive) |-> lowLevelExceeded)
		else $error("noise valid unqualified");
	a_noise_pass: assert property (@(posedge clk) disable iff (!rst_b)
		!lowActive |=> noiseDetectValid == $past(noiseDetectRaw))
		else $error("noise detect not passed");

	// events: set wins over write-one-to-clear
	always_comb begin
		irqEvents = 8'h00;
		irqEvents[IRQ_DET_RISE] = detNext && !detReg;
		irqEvents[IRQ_DET_FALL] = !detNext && detReg;
		irqEvents[IRQ_LOW_RISE] = lowNext && !lowReg;
		irqStatusNext = irqStatusReg;
		if (regWrite && regAddr == OFS_IRQ_STATUS) begin
			irqStatusNext = irqStatusNext & ~regWdata;
		end
		irqStatusNext = irqStatusNext | irqEvents;
	end

	// an event in the cycle of a clear still leaves its bit set
	a_irq_set: assert property (@(posedge clk) disable iff (!rst_b)
		irqEvents[IRQ_DET_RISE] |=> irqStatusReg[IRQ_DET_RISE])
		else $error("detect event lost");

	// read mux, answer in the following cycle; unmapped reads zero
	always_comb begin
		rdataNext = 8'h00;
		if (regRead) begin
			unique case (regAddr)
				OFS_SLICER:     rdataNext = slicerReg;
				OFS_RATE:       rdataNext = rateReg;
				OFS_THR_RUN:    rdataNext = thrRunReg;
				OFS_THR_WAKE:   rdataNext = thrWakeReg;
				OFS_THR_LOW:    rdataNext = thrLowReg;
				OFS_RANGE:      rdataNext = rangeReg;
				OFS_FILTER:     rdataNext = filterReg;
				OFS_NOISE_CFG:  rdataNext = ndcfgReg;
				OFS_IRQ_STATUS: rdataNext = irqStatusReg;
				OFS_IRQ_MASK:   rdataNext = irqMaskReg;
				OFS_DET_STATE:  rdataNext = {5'h00, nvalidReg, lowReg, detReg};
				default:        rdataNext = 8'h00;
			endcase
		end
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			slicerReg    <= RST_SLICER;
			rateReg      <= RST_RATE;
			thrRunReg    <= RST_THR;
			thrWakeReg   <= RST_THR;
			thrLowReg    <= RST_THR;
			rangeReg     <= RST_RANGE;
			filterReg    <= RST_FILTER;
			ndcfgReg     <= RST_NOISE_CFG;
			irqStatusReg <= 8'h00;
			irqMaskReg   <= 8'h00;
			rdataReg     <= 8'h00;
			detReg       <= 1'b0;
			lowReg       <= 1'b0;
			nvalidReg    <= 1'b0;
		end else begin
			slicerReg    <= slicerNext;
			rateReg      <= rateNext;
			thrRunReg    <= thrRunNext;
			thrWakeReg   <= thrWakeNext;
			thrLowReg    <= thrLowNext;
			rangeReg     <= rangeNext;
			filterReg    <= filterNext;
			ndcfgReg     <= ndcfgNext;
			irqStatusReg <= irqStatusNext;
			irqMaskReg   <= irqMaskNext;
			rdataReg     <= rdataNext;
			detReg       <= detNext;
			lowReg       <= lowNext;
			nvalidReg    <= nvalidNext;
		end
	end

	// codes 110 and 111 are not to be programmed; divisor then reads zero
	always_comb begin
		filterLength     = {1'b0, filterReg[3:0]} + 5'h01;
		rateTuneWord     = rateReg;
		slicerBwScaling  = slicerReg[BW_SCA_LSB +: 2];
		slicerScaleShift = {3'h0, slicerBwScaling} + 5'h01;
		slicerBwSelect   = slicerReg[BW_SEL_LSB +: 3];
		slicerBwDivisor  = (slicerBwSelect <= 3'h5) ?
			6'({slicerBwSelect, 3'h0} + 6'h08) : 6'h00;
		detectorSelect   = ndcfgReg[DET_SEL_LSB +: 2];
	end

	// static decodes of the stored fields
	a_filter_len: assert property (@(posedge clk) disable iff (!rst_b)
		filterLength == filterReg[3:0] + 5'h01)
		else $error("filter length wrong");
	a_filter_max: assert property (@(posedge clk) disable iff (!rst_b)
		filterReg[3:0] == 4'hF |-> filterLength == 5'h10)
		else $error("longest filter wrong");
	a_slicer_shift: assert property (@(posedge clk) disable iff (!rst_b)
		slicerBwScaling == 2'h3 |-> slicerScaleShift == 5'h04)
		else $error("slicer scaling wrong");
	a_slicer_unused: assert property (@(posedge clk) disable iff (!rst_b)
		slicerBwSelect > 3'h5 |-> slicerBwDivisor == 6'h00)
		else $error("unused slicer code decoded");
	a_slicer_max: assert property (@(posedge clk) disable iff (!rst_b)
		slicerBwSelect == 3'h5 |-> slicerBwDivisor == 6'h30)
		else $error("slicer divisor wrong");

	assign regRdata         = rdataReg;
	assign signalDetect     = detReg;
	assign lowLevelExceeded = lowReg;
	assign noiseDetectValid = nvalidReg;
	assign irq              = |(irqStatusReg & irqMaskReg);

	c_detect_rise: cover property (@(posedge clk) disable iff (!rst_b)
		!signalDetect ##1 signalDetect);
	c_irq_up: cover property (@(posedge clk) disable iff (!rst_b) irq);
	c_noise_mode3: cover property (@(posedge clk) disable iff (!rst_b)
		lowActive && noiseDetectValid);
	c_wake_detect: cover property (@(posedge clk) disable iff (!rst_b)
		wakeupMode && signalDetect);
endmodule
`default_nettype wire

/* File: testbench/tb_baseband_detector_config_bank.sv */
// self-checking bench for the baseband detector configuration bank
// assumes the single-cycle register port and the detect outputs as declared in src
`timescale 1ns/100ps
`default_nettype none
`define CHK(got, exp) begin samplesChecked++; if ((got) !== (exp)) begin nErrors++; \
	$display("BAD %0t got %h exp %h", $time, got, exp); end end
module tb_baseband_detector_config_bank;
	import detector_cfg_pkg::*;
	logic        clk = 1'b0, rst_b = 1'b0, regWrite = 1'b0, regRead = 1'b0;
	logic [8:0]  regAddr = 9'h0;
	logic [7:0]  regWdata = 8'h0, regRdata, rateTuneWord;
	logic        wakeupMode = 1'b0, fskMode = 1'b0, noiseDetectRaw = 1'b0;
	logic [23:0] signalPower = 24'h0;
	logic [4:0]  filterLength, slicerScaleShift;
	logic [1:0]  slicerBwScaling, detectorSelect;
	logic [2:0]  slicerBwSelect;
	logic [5:0]  slicerBwDivisor;
	logic        signalDetect, lowLevelExceeded, noiseDetectValid, irq;
	int          nErrors = 0, samplesChecked = 0;
	// last entry is an unmapped place: reads zero, writes dropped
	localparam logic [8:0] ADDR_T [9] = '{OFS_SLICER, OFS_RATE, OFS_THR_RUN, OFS_THR_WAKE,
		OFS_THR_LOW, OFS_RANGE, OFS_FILTER, OFS_NOISE_CFG, 9'h0AA};
	localparam logic [7:0] RST_T [9] = '{RST_SLICER, RST_RATE, RST_THR, RST_THR, RST_THR,
		RST_RANGE, RST_FILTER, RST_NOISE_CFG, 8'h00};
	localparam logic [7:0] MSK_T [9] = '{MSK_SLICER, 8'hFF, 8'hFF, 8'hFF, 8'hFF, MSK_RANGE,
		MSK_FILTER, 8'hFF, 8'h00};

	always #20 clk = ~clk;

	baseband_detector_config_bank baseband_detector_config_bank_i (
		.clk(clk), .rst_b(rst_b), .regAddr(regAddr), .regWdata(regWdata), .regWrite(regWrite),
		.regRead(regRead), .regRdata(regRdata), .wakeupMode(wakeupMode), .fskMode(fskMode),
		.signalPower(signalPower), .noiseDetectRaw(noiseDetectRaw), .filterLength(filterLength),
		.rateTuneWord(rateTuneWord), .slicerBwScaling(slicerBwScaling),
		.slicerBwSelect(slicerBwSelect), .slicerScaleShift(slicerScaleShift),
		.slicerBwDivisor(slicerBwDivisor), .detectorSelect(detectorSelect),
		.signalDetect(signalDetect), .lowLevelExceeded(lowLevelExceeded),
		.noiseDetectValid(noiseDetectValid), .irq(irq));

	task automatic wr(input logic [8:0] a, input logic [7:0] d);
		@(posedge clk);
		regAddr <= a;
		regWdata <= d;
		regWrite <= 1'b1;
		@(posedge clk);
		regWrite <= 1'b0;
	endtask

	// read data stand only in the cycle after the strobe, so sample just past that edge
	task automatic rd(input logic [8:0] a, output logic [7:0] d);
		@(posedge clk);
		regAddr <= a;
		regRead <= 1'b1;
		@(posedge clk);
		regRead <= 1'b0;
		#1 d = regRdata;
	endtask

	task automatic cyc(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask

	function automatic logic [3:0] factor(input logic fsk, input logic [1:0] c);
		if (fsk)
			return {1'b0, c, 1'b0} + 4'h2;
		return (c == 2'h0) ? 4'h6 : (c == 2'h1) ? 4'h7 : (c == 2'h2) ? 4'hD : 4'h8;
	endfunction

	task automatic give_verdict;
		$display("comparisons %0d mismatches %0d", samplesChecked, nErrors);
		if (nErrors == 0 && samplesChecked > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask

	// generous bound: the sequence needs under 1500 cycles
	initial begin
		#(40 * 20000);
		nErrors++;
		give_verdict();
	end

	initial begin
		logic [7:0]  d, v, thrRun, thrWake, thrLow, rng;
		logic [23:0] sc, scLo;
		logic [1:0]  sel;
		logic        fsk, wk, raw, lowExp;
		void'($urandom(32'h52399e6f));
		repeat (5) @(posedge clk);
		rst_b <= 1'b1;
		cyc(1);
		`CHK(filterLength, 5'h08)
		`CHK(slicerBwDivisor, 6'h18)
		for (int i = 0; i < 9; i++) begin
			rd(ADDR_T[i], d);
			`CHK(d, RST_T[i])
		end
		for (int i = 0; i < 9; i++) begin
			v = 8'($urandom);
			wr(ADDR_T[i], v);
			rd(ADDR_T[i], d);
			`CHK(d, v & MSK_T[i])
		end
		for (int i = 0; i < 32; i++) begin
			v = (i == 0) ? 8'h00 : (i == 31) ? 8'hFF : 8'($urandom);
			wr(OFS_FILTER, 8'(i));
			wr(OFS_SLICER, 8'(i));
			wr(OFS_RATE, v);
			cyc(1);
			`CHK(filterLength, 5'(i[3:0]) + 5'h1)
			`CHK(rateTuneWord, v)
			`CHK(slicerScaleShift, 5'(i[4:3]) + 5'h1)
			`CHK(slicerBwScaling, 2'(i[4:3]))
			`CHK(slicerBwSelect, 3'(i[2:0]))
			`CHK(slicerBwDivisor, (i[2:0] < 6) ? 6'(8 * (i[2:0] + 1)) : 6'h0)
		end
		// power lands on, just above, or around the scaled thresholds
		for (int k = 0; k < 80; k++) begin
			thrRun = 8'($urandom);
			thrWake = 8'($urandom);
			thrLow = 8'($urandom);
			rng = 8'($urandom) & 8'h3F;
			sel = 2'($urandom);
			{fsk, wk, raw} = 3'($urandom);
			wr(OFS_THR_RUN, thrRun);
			wr(OFS_THR_WAKE, thrWake);
			wr(OFS_THR_LOW, thrLow);
			wr(OFS_RANGE, rng);
			wr(OFS_NOISE_CFG, {2'h0, sel, 4'h7});
			sc = {16'h0, wk ? thrWake : thrRun} << factor(fsk, fsk ? rng[3:2] : rng[5:4]);
			scLo = {16'h0, thrLow} << factor(1'b1, rng[1:0]);
			@(posedge clk);
			fskMode <= fsk;
			wakeupMode <= wk;
			noiseDetectRaw <= raw;
			signalPower <= (k % 4 == 0) ? sc : (k % 4 == 1) ? sc + 24'h1 :
				(k % 4 == 2) ? scLo + 24'(k % 8 == 2) : 24'($urandom) & 24'h1FFFFF;
			cyc(3);
			lowExp = (sel == 2'h3) && (signalPower > scLo);
			if (fsk) `CHK(signalDetect, signalPower > sc)
			else `CHK(signalDetect, signalPower > sc)
			`CHK(detectorSelect, sel)
			`CHK(lowLevelExceeded, lowExp)
			`CHK(noiseDetectValid, (sel == 2'h3) ? raw & lowExp : raw)
		end
		@(posedge clk);
		signalPower <= 24'h0;
		cyc(3);
		wr(OFS_IRQ_STATUS, 8'h07);
		rd(OFS_IRQ_STATUS, d);
		`CHK(d, 8'h00)
		wr(OFS_IRQ_MASK, 8'h01);
		wr(OFS_THR_RUN, 8'h01);
		wr(OFS_RANGE, 8'h00);
		@(posedge clk);
		fskMode <= 1'b0;
		wakeupMode <= 1'b0;
		signalPower <= 24'h41;
		cyc(3);
		`CHK(signalDetect, 1'b1)
		`CHK(irq, 1'b1)
		rd(OFS_IRQ_STATUS, d);
		`CHK(d[IRQ_DET_RISE], 1'b1)
		wr(OFS_IRQ_MASK, 8'h00);
		cyc(1);
		`CHK(irq, 1'b0)
		wr(OFS_IRQ_MASK, 8'h01);
		wr(OFS_IRQ_STATUS, 8'h01);
		cyc(1);
		`CHK(irq, 1'b0)
		// a falling detect is logged but stays masked
		@(posedge clk);
		signalPower <= 24'h0;
		cyc(3);
		`CHK(signalDetect, 1'b0)
		`CHK(irq, 1'b0)
		rd(OFS_IRQ_STATUS, d);
		`CHK(d[IRQ_DET_FALL], 1'b1)
		give_verdict();
	end
endmodule
`default_nettype wire
